// ---- src/csc_regs.svh ----
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// ----------------------------------------------------------------
// Bus addresses and command codes
// ----------------------------------------------------------------
`define CSC_ADDR_OWN_WR    8'h12
`define CSC_ADDR_ARA_RD    8'h19
`define CSC_ARA_REPLY      8'h13
`define CSC_CMD_MODE       8'h12
`define CSC_CMD_CUR        8'h14
`define CSC_CMD_VOLT       8'h15
`define CSC_CMD_ALARM      8'h16

// ----------------------------------------------------------------
// Set point fields and limits
// ----------------------------------------------------------------
`define CSC_CUR_RESET      16'h0080
`define CSC_VOLT_RESET     16'h4800
`define CSC_CUR_KEEP       16'hffc0
`define CSC_VOLT_KEEP      16'hfff0
`define CSC_CUR_MAX        16'h0bc0
`define CSC_CUR_MIN        16'h0080
`define CSC_VOLT_MAX       16'h4800
`define CSC_VOLT_MIN       16'h0400
`define CSC_CUR_CODE_HI    11
`define CSC_CUR_CODE_LO    6
`define CSC_VOLT_CODE_HI   14
`define CSC_VOLT_CODE_LO   4
`define CSC_ALARM_KEEP     16'hf800

// ----------------------------------------------------------------
// Mode word fields
// ----------------------------------------------------------------
`define CSC_MODE_POR_BIT   3
`define CSC_MODE_SRC_BIT   6
`define CSC_MODE_PACK_BIT  5
`define CSC_MODE_ADPT_BIT  4
`define CSC_MASK_RESET     3'h0

// ----------------------------------------------------------------
// Link bit counting
// ----------------------------------------------------------------
`define CSC_BIT_LAST       4'h7
`define CSC_BIT_AFTER_STRT 4'h2

// ----------------------------------------------------------------
// Safety timer
// ----------------------------------------------------------------
`define CSC_TIMEOUT_S      175
`define CSC_TICK_NS        1000000
`define CSC_CLK_NS         8
`define CSC_TICK_CYCLES    (`CSC_TICK_NS / `CSC_CLK_NS)
`define CSC_TIMEOUT_TICKS  (`CSC_TIMEOUT_S * (1000000000 / `CSC_TICK_NS))

`endif

// ---- src/csc_pkg.sv ----
package csc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CSC_PRESC_W = 24;
  localparam int CSC_TICK_W  = 20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic adapter;
    logic pack;
    logic src_low;
  } csc_stat_t;

  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_CMD, LK_DLO, LK_DHI, LK_ACK, LK_ARA, LK_IGN
  } csc_phase_t;

  typedef struct packed {
    logic [5:0]  cur_code;
    logic [10:0] volt_code;
    logic        cur_over;
    logic        volt_over;
    logic        cur_off;
    logic        volt_off;
    logic        reg_on;
  } csc_charge_t;

  typedef struct packed {
    logic       start_m;
    logic       start_s;
    logic       start_seen;
    logic       pend_m;
    logic       pend_s;
    csc_phase_t phase;
    csc_phase_t after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] cmd;
    logic [7:0] dlo;
    logic [15:0] data;
    logic       word_tog;
    logic       addr_tog;
    logic       ara_tog;
    logic       oe;
  } csc_link_t;

  typedef struct packed {
    logic                   scl_m;
    logic                   scl_s;
    logic                   sda_m;
    logic                   sda_s;
    logic                   sda_d;
    logic                   start_tog;
    logic [2:0]             word_y;
    logic [2:0]             addr_y;
    logic [2:0]             ara_y;
    csc_stat_t              stat_m;
    csc_stat_t              stat_s;
    csc_stat_t              stat_d;
    logic [15:0]            cur;
    logic [15:0]            volt;
    csc_stat_t              mask;
    csc_stat_t              pend;
    logic                   block;
    logic                   got_cur;
    logic                   got_volt;
    logic                   timeout;
    logic [CSC_PRESC_W-1:0] presc;
    logic [CSC_TICK_W-1:0]  ticks;
    csc_charge_t            out;
  } csc_sys_t;

endpackage

// ---- src/csc_smbus_cmd.sv ----
// Summary of operation
// [R01] Current command 0x14 keeps 64mA steps only.
// [R02] Current above 3008mA flags overrange and clamps.
// [R03] Current below 128mA switches charge current off.
// [R04] Current resets to 0x0080, also on removal.
// [R05] Voltage command 0x15 keeps 16mV steps only.
// [R06] Voltage at/above 18432mV flags overrange, clamps.
// [R07] Voltage below 1024mV terminates charging.
// [R08] Voltage resets to 0x4800, also on removal.
// [R09] Alarm command bits 15..11 set charge block.
// [R10] Block clears: removal, reinit, both set points.
// [R11] Regulator held off while block is set.
// [R12] Interrupt on change of three status inputs.
// [R13] Mode bits 6,5,4 mask those interrupt sources.
// [R14] Any command to us clears pending interrupts.
// [R15] Alert address read answers 0x13, clears on win.
// [R16] Host repeats alert reads until all cleared.
// [R17] No set point for 175s terminates charging.
// [R18] Each set point command restarts the timer.
// [R19] After timeout both set points, reinit or removal resume.
// [R20] Power-on charges at 128mA default immediately.
// [R21] Timer expiry also sets the charge block.
// [R22] Prescaled timer; open-drain interrupt output.
`timescale 1ns/10ps
`include "csc_regs.svh"

module csc_smbus_cmd
  import csc_pkg::*;
#(
  parameter int TICK_CYCLES   = `CSC_TICK_CYCLES,
  parameter int TIMEOUT_TICKS = `CSC_TIMEOUT_TICKS
) (
  // System clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Bus clock pin, clocks the link logic
  input  wire logic        scl_clk,
  // Bus data pin
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Status inputs from the analog side
  input  wire logic        src_below_batt,
  input  wire logic        pack_detected,
  input  wire logic        adapter_detected,
  // Open-drain interrupt pin
  output logic             int_o,
  output logic             int_oe,
  // Charge control
  output csc_charge_t      charge,
  output logic             charge_block_flag,
  output logic             safety_timeout
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << CSC_PRESC_W)) begin : g_bad_tick
    $error("TICK_CYCLES out of range.");
  end
  if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS >= (1 << CSC_TICK_W)) begin : g_bad_to
    $error("TIMEOUT_TICKS out of range.");
  end

  localparam logic [CSC_PRESC_W-1:0] PRESC_LAST = CSC_PRESC_W'(TICK_CYCLES - 1);
  localparam logic [CSC_TICK_W-1:0]  TICKS_LAST = CSC_TICK_W'(TIMEOUT_TICKS - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  function automatic logic edge_seen(input logic [2:0] y);
    edge_seen = y[2] ^ y[1];
  endfunction

  csc_link_t lq;
  csc_link_t next_lq;
  csc_sys_t  sq;
  csc_sys_t  next_sq;

  // ----------------------------------------------------------------
  // Link domain, falling edge of the bus clock
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] rx;
    rx = {lq.sh[6:0], sda_i};
    next_lq = lq;
    next_lq.start_m = sq.start_tog;
    next_lq.start_s = lq.start_m;
    next_lq.pend_m  = |sq.pend;
    next_lq.pend_s  = lq.pend_m;
    next_lq.sh      = rx;
    next_lq.cnt     = lq.cnt + 4'h1;
    if (lq.start_s != lq.start_seen) begin
      next_lq.start_seen = lq.start_s;
      next_lq.phase      = LK_ADDR;
      next_lq.cnt        = `CSC_BIT_AFTER_STRT;
      next_lq.oe         = 1'b0;
    end else begin
      case (lq.phase)
        LK_ADDR, LK_CMD, LK_DLO, LK_DHI: begin
          if (lq.cnt == `CSC_BIT_LAST) begin
            next_lq.phase = LK_ACK;
            next_lq.oe    = 1'b1;
            case (lq.phase)
              LK_ADDR: begin
                if (rx == `CSC_ADDR_OWN_WR) begin
                  next_lq.after    = LK_CMD;
                  next_lq.addr_tog = ~lq.addr_tog; // see [R14]
                end else if (rx == `CSC_ADDR_ARA_RD && lq.pend_s) begin
                  next_lq.after = LK_ARA; // see [R15]
                end else begin
                  next_lq.phase = LK_IGN;
                  next_lq.oe    = 1'b0;
                end
              end
              LK_CMD: begin
                next_lq.cmd   = rx;
                next_lq.after = LK_DLO;
              end
              LK_DLO: begin
                next_lq.dlo   = rx;
                next_lq.after = LK_DHI;
              end
              default: begin
                next_lq.data     = {rx, lq.dlo};
                next_lq.word_tog = ~lq.word_tog;
                next_lq.after    = LK_IGN;
              end
            endcase
          end
        end
        LK_ACK: begin
          next_lq.cnt   = 4'h0;
          next_lq.phase = lq.after;
          next_lq.oe    = 1'b0;
          if (lq.after == LK_ARA) begin
            next_lq.tx = `CSC_ARA_REPLY; // see [R15]
            next_lq.oe = ~next_lq.tx[7];
          end
        end
        LK_ARA: begin
          if (lq.tx[7] && !sda_i) begin
            next_lq.phase = LK_IGN; // see [R15]
            next_lq.oe    = 1'b0;
          end else if (lq.cnt == `CSC_BIT_LAST) begin
            next_lq.phase   = LK_IGN;
            next_lq.oe      = 1'b0;
            next_lq.ara_tog = ~lq.ara_tog; // see [R15]
          end else begin
            next_lq.tx = {lq.tx[6:0], 1'b1};
            next_lq.oe = ~lq.tx[6];
          end
        end
        LK_IDLE, LK_IGN: begin
          next_lq.cnt = 4'h0;
        end
        default: begin
          next_lq.phase = LK_IGN;
          next_lq.oe    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      lq <= '0;
    end else begin
      lq <= next_lq;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = lq.oe;

  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------
  always_comb begin
    logic      word_ev;
    logic      clr_irq;
    logic      tick;
    logic      setpt;
    csc_stat_t change;
    logic [15:0] cur_c;
    logic [15:0] volt_c;
    next_sq = sq;
    next_sq.scl_m  = scl_clk;
    next_sq.scl_s  = sq.scl_m;
    next_sq.sda_m  = sda_i;
    next_sq.sda_s  = sq.sda_m;
    next_sq.sda_d  = sq.sda_s;
    next_sq.word_y = {sq.word_y[1:0], lq.word_tog};
    next_sq.addr_y = {sq.addr_y[1:0], lq.addr_tog};
    next_sq.ara_y  = {sq.ara_y[1:0], lq.ara_tog};
    next_sq.stat_m = '{adapter: adapter_detected, pack: pack_detected,
                       src_low: src_below_batt};
    next_sq.stat_s = sq.stat_m;
    next_sq.stat_d = sq.stat_s;
    if (sq.scl_s && sq.sda_d && !sq.sda_s) begin
      next_sq.start_tog = ~sq.start_tog;
    end
    word_ev = edge_seen(sq.word_y);
    clr_irq = edge_seen(sq.addr_y) || edge_seen(sq.ara_y);
    setpt   = 1'b0;

    if (word_ev) begin
      case (lq.cmd)
        `CSC_CMD_CUR: begin
          next_sq.cur     = lq.data & `CSC_CUR_KEEP; // see [R01]
          next_sq.got_cur = 1'b1;
          setpt           = 1'b1;
        end
        `CSC_CMD_VOLT: begin
          next_sq.volt     = lq.data & `CSC_VOLT_KEEP; // see [R05]
          next_sq.got_volt = 1'b1;
          setpt            = 1'b1;
        end
        `CSC_CMD_MODE: begin
          next_sq.mask = '{adapter: lq.data[`CSC_MODE_ADPT_BIT],
                           pack:    lq.data[`CSC_MODE_PACK_BIT],
                           src_low: lq.data[`CSC_MODE_SRC_BIT]}; // see [R13]
          if (lq.data[`CSC_MODE_POR_BIT]) begin
            next_sq.cur     = `CSC_CUR_RESET;
            next_sq.volt    = `CSC_VOLT_RESET;
            next_sq.block   = 1'b0; // see [R10]
            next_sq.timeout = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (next_sq.got_cur && next_sq.got_volt) begin
      next_sq.block    = 1'b0; // see [R10]
      next_sq.timeout  = 1'b0; // see [R19]
      next_sq.got_cur  = 1'b0;
      next_sq.got_volt = 1'b0;
    end

    if (!sq.stat_s.pack) begin
      next_sq.cur      = `CSC_CUR_RESET; // see [R04]
      next_sq.volt     = `CSC_VOLT_RESET; // see [R08]
      next_sq.block    = 1'b0; // see [R10]
      next_sq.timeout  = 1'b0;
      next_sq.got_cur  = 1'b0;
      next_sq.got_volt = 1'b0;
    end

    tick = (sq.presc == PRESC_LAST);
    if (setpt || sq.block) begin
      next_sq.presc = '0; // see [R18]
      next_sq.ticks = '0;
    end else begin
      next_sq.presc = tick ? '0 : sq.presc + 1'b1; // see [R22]
      if (tick) begin
        next_sq.ticks = sq.ticks + 1'b1;
        if (sq.ticks == TICKS_LAST) begin
          next_sq.ticks    = '0;
          next_sq.block    = 1'b1; // see [R17] [R21]
          next_sq.timeout  = 1'b1;
          next_sq.got_cur  = 1'b0; // see [R19]
          next_sq.got_volt = 1'b0;
        end
      end
    end

    if (word_ev && lq.cmd == `CSC_CMD_ALARM && |(lq.data & `CSC_ALARM_KEEP)) begin
      next_sq.block    = 1'b1; // see [R09]
      next_sq.got_cur  = 1'b0;
      next_sq.got_volt = 1'b0;
    end

    change = sq.stat_s ^ sq.stat_d;
    next_sq.pend = (clr_irq ? '0 : sq.pend) | (change & ~sq.mask); // see [R12] [R14]

    cur_c  = clamp(sq.cur, `CSC_CUR_MAX);
    volt_c = clamp(sq.volt, `CSC_VOLT_MAX);
    next_sq.out.cur_code  = cur_c[`CSC_CUR_CODE_HI:`CSC_CUR_CODE_LO]; // see [R02]
    next_sq.out.volt_code = volt_c[`CSC_VOLT_CODE_HI:`CSC_VOLT_CODE_LO]; // see [R06]
    next_sq.out.cur_over  = sq.cur > `CSC_CUR_MAX; // see [R02]
    next_sq.out.volt_over = sq.volt >= `CSC_VOLT_MAX; // see [R06]
    next_sq.out.cur_off   = sq.cur < `CSC_CUR_MIN; // see [R03]
    next_sq.out.volt_off  = sq.volt < `CSC_VOLT_MIN; // see [R07]
    next_sq.out.reg_on    = !sq.block && !next_sq.out.cur_off
                            && !next_sq.out.volt_off; // see [R11] [R20]
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sq      <= '0;
      sq.cur  <= `CSC_CUR_RESET; // see [R04] [R20]
      sq.volt <= `CSC_VOLT_RESET; // see [R08]
      sq.mask <= `CSC_MASK_RESET;
    end else begin
      sq <= next_sq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign int_o             = 1'b0;
  assign int_oe            = |sq.pend; // see [R22]
  assign charge            = sq.out;
  assign charge_block_flag = sq.block;
  assign safety_timeout    = sq.timeout;

endmodule

// ---- tb/csc_cmd_properties.sv ----
`timescale 1ns/10ps
module csc_cmd_checker
  import csc_pkg::*;
#(
  parameter int TICK_CYCLES   = 125000,
  parameter int TIMEOUT_TICKS = 175000
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Pins and status
  input wire logic        sda_o,
  input wire logic        int_o,
  input wire logic        int_oe,
  input wire logic        src_below_batt,
  input wire logic        pack_detected,
  input wire logic        adapter_detected,
  // Charge control
  input wire csc_charge_t charge,
  input wire logic        charge_block_flag,
  input wire logic        safety_timeout
);
  localparam longint LIMIT = longint'(TICK_CYCLES) * TIMEOUT_TICKS - TICK_CYCLES;
  logic [39:0] since_rst;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      since_rst <= 40'h0;
    end else if (since_rst < 40'hffffffffff) begin
      since_rst <= since_rst + 40'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence defaults_seen;
    charge.cur_code == 6'h02 && charge.volt_code == 11'h480 && charge.reg_on;
  endsequence
  sequence status_quiet;
    since_rst > 40'h10 && $stable({src_below_batt, pack_detected, adapter_detected});
  endsequence
  reset_defaults_a: assert property ($rose(rst_n) |-> ##[1:2] defaults_seen)
    else $error("bad set points after reset");
  block_holds_off_a: assert property (charge_block_flag [*2] |-> !charge.reg_on)
    else $error("regulator on while blocked");
  off_codes_stop_a: assert property (charge.cur_off || charge.volt_off |-> !charge.reg_on)
    else $error("regulator on with low code");
  cur_clamp_a: assert property (charge.cur_over |-> charge.cur_code == 6'h2f)
    else $error("current not clamped");
  volt_clamp_a: assert property (charge.volt_over |-> charge.volt_code == 11'h480)
    else $error("voltage not clamped");
  timeout_blocks_a: assert property ($rose(safety_timeout) |-> ##[0:1] charge_block_flag ##1 !charge.reg_on)
    else $error("timeout left charging on");
  timeout_late_a: assert property ($rose(safety_timeout) |-> since_rst >= LIMIT)
    else $error("timeout too early");
  irq_cause_a: assert property (status_quiet [*8] |=> !$rose(int_oe))
    else $error("interrupt without status change");
  open_drain_a: assert property (!sda_o && !int_o)
    else $error("open-drain output high");
endmodule
bind csc_smbus_cmd csc_cmd_checker #(
  .TICK_CYCLES(TICK_CYCLES), .TIMEOUT_TICKS(TIMEOUT_TICKS)
) chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .sda_o(sda_o), .int_o(int_o), .int_oe(int_oe),
  .src_below_batt(src_below_batt), .pack_detected(pack_detected),
  .adapter_detected(adapter_detected), .charge(charge),
  .charge_block_flag(charge_block_flag), .safety_timeout(safety_timeout)
);

// ---- tb/csc_host_model.sv ----
`timescale 1ns/10ps
module csc_host_model (
  // Bus lines
  output logic      scl_clk,
  output logic      sda_i,
  input  wire logic sda_oe
);
  logic       drv;
  logic [7:0] rd;
  // The data line has a pull-up, so a released line reads high.
  assign sda_i = drv & ~sda_oe;
  initial begin
    scl_clk = 1'b1;
    drv     = 1'b1;
    rd      = 8'h00;
  end
  task automatic clk_bit(input logic b);
    drv = b;
    #12;
    scl_clk = 1'b1;
    rd = {rd[6:0], sda_i};
    #24;
    scl_clk = 1'b0;
    #12;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i]);
    end
    clk_bit(1'b1);
    ack = ~rd[0];
  endtask
  task automatic start_frame();
    #7;
    drv = 1'b0;
    #48;
    scl_clk = 1'b0;
    #12;
  endtask
  task automatic stop_frame();
    drv = 1'b0;
    #12;
    scl_clk = 1'b1;
    #12;
    drv = 1'b1;
    #24;
  endtask
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
    logic a0, a1, a2, a3;
    start_frame();
    send(8'h12, a0);
    send(cmd, a1);
    send(d[7:0], a2);
    send(d[15:8], a3);
    stop_frame();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic ara_read(input logic [7:0] rival, output logic [7:0] got, output logic ok);
    start_frame();
    send(8'h19, ok);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(rival[i]);
    end
    got = rd;
    clk_bit(1'b1);
    stop_frame();
  endtask
endmodule

// ---- tb/charger_smbus_command_logic_test.sv ----
`timescale 1ns/10ps
module charger_smbus_command_logic_test
  import csc_pkg::*;
;
  logic        clk_sys, rst_n, scl_clk, sda_i, sda_oe, int_oe, ok;
  logic        src_below_batt, pack_detected, adapter_detected;
  logic        charge_block_flag, safety_timeout;
  csc_charge_t charge;
  logic [15:0] cur_sp, volt_sp;
  logic [7:0]  rb;
  int          failures, tests_run;
  csc_smbus_cmd #(.TICK_CYCLES(32), .TIMEOUT_TICKS(160)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(),
    .sda_oe(sda_oe), .src_below_batt(src_below_batt), .pack_detected(pack_detected),
    .adapter_detected(adapter_detected), .int_o(), .int_oe(int_oe), .charge(charge),
    .charge_block_flag(charge_block_flag), .safety_timeout(safety_timeout)
  );
  csc_host_model host (.scl_clk(scl_clk), .sda_i(sda_i), .sda_oe(sda_oe));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic csc_charge_t exp_chg(logic [15:0] c, logic [15:0] v, logic b);
    csc_charge_t e;
    logic [15:0] ct, vt;
    ct = c & 16'hffc0;
    vt = v & 16'hfff0;
    e.cur_over = ct > 16'h0bc0;
    e.volt_over = vt >= 16'h4800;
    e.cur_off = ct < 16'h0080;
    e.volt_off = vt < 16'h0400;
    e.cur_code = e.cur_over ? 6'h2f : ct[11:6];
    e.volt_code = e.volt_over ? 11'h480 : vt[14:4];
    e.reg_on = !b && !e.cur_off && !e.volt_off;
    return e;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] cmd, input logic [15:0] d, input logic b);
    host.write_word(cmd, d, ok);
    step(12);
    if (cmd == 8'h14) cur_sp = d;
    if (cmd == 8'h15) volt_sp = d;
    if (cmd == 8'h12 && d[3]) begin
      cur_sp = 16'h0080;
      volt_sp = 16'h4800;
    end
    check(ok, 1'b1);
    check(charge, exp_chg(cur_sp, volt_sp, b));
    check(charge_block_flag, b);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_current();
    put(8'h14, 16'h0bff, 1'b0);
    check(int_oe, 1'b0);
    put(8'h14, 16'h0c00, 1'b0);
    put(8'h14, 16'h007f, 1'b0);
    put(8'h14, 16'h00bf, 1'b0);
    $display("current done");
  endtask
  task automatic t_voltage();
    put(8'h15, 16'h47ff, 1'b0);
    put(8'h15, 16'h4800, 1'b0);
    put(8'h15, 16'h8010, 1'b0);
    put(8'h15, 16'h03ff, 1'b0);
    put(8'h15, 16'h3000, 1'b0);
    $display("voltage done");
  endtask
  task automatic t_alarm();
    put(8'h16, 16'h07ff, 1'b0);
    for (int i = 0; i < 5; i++) begin
      put(8'h16, 16'h0800 << i, 1'b1);
      put(8'h14, 16'h0400, 1'b1);
      put(8'h15, 16'h3000, 1'b0);
    end
    put(8'h16, 16'h8000, 1'b1);
    put(8'h12, 16'h0008, 1'b0);
    $display("alarm done");
  endtask
  task automatic t_irq();
    put(8'h12, 16'h0070, 1'b0);
    src_below_batt = 1'b1;
    adapter_detected = 1'b1;
    step(10);
    check(int_oe, 1'b0);
    put(8'h12, 16'h0000, 1'b0);
    src_below_batt = 1'b0;
    step(10);
    check(int_oe, 1'b1);
    host.ara_read(8'h11, rb, ok);
    step(10);
    check(int_oe, 1'b1);
    host.ara_read(8'hff, rb, ok);
    step(10);
    check(rb, 8'h13);
    check(int_oe, 1'b0);
    put(8'h16, 16'h8000, 1'b1);
    pack_detected = 1'b0;
    step(10);
    cur_sp = 16'h0080;
    volt_sp = 16'h4800;
    check(charge, exp_chg(cur_sp, volt_sp, 1'b0));
    check(charge_block_flag, 1'b0);
    pack_detected = 1'b1;
    $display("interrupt done");
  endtask
  task automatic t_timer();
    put(8'h14, 16'h0400, 1'b0);
    put(8'h15, 16'h3000, 1'b0);
    step(4000);
    put(8'h14, 16'h0400, 1'b0);
    step(4000);
    check(safety_timeout, 1'b0);
    for (int n = 0; n < 2000 && safety_timeout !== 1'b1; n++) begin
      step(1);
    end
    check(safety_timeout, 1'b1);
    step(1);
    check(charge, exp_chg(cur_sp, volt_sp, 1'b1));
    put(8'h14, 16'h0400, 1'b1);
    put(8'h15, 16'h3000, 1'b0);
    $display("timer done");
  endtask
  initial begin
    rst_n = 1'b0;
    src_below_batt = 1'b0;
    pack_detected = 1'b1;
    adapter_detected = 1'b0;
    cur_sp = 16'h0080;
    volt_sp = 16'h4800;
    failures = 0;
    tests_run = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    step(10);
    check(charge, exp_chg(cur_sp, volt_sp, 1'b0));
    check(int_oe, 1'b1);
    $display("reset done");
    t_current();
    t_voltage();
    t_alarm();
    t_irq();
    t_timer();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
endmodule
